//--- verilog/nv_access.sv
// processor access control for the byte-wide nonvolatile data array
// assumes io_* strobes come from the core on ref_clk; rstn and por_n
// are asynchronous; global_irq_en and self_prog_busy are core logic
module nv_access
	import nv_access_pkg::*;
#(
	parameter int ADDR_W = 11,
	parameter int ATOMIC_CYC = ATOMIC_CYCLES,
	parameter int SPLIT_CYC = SPLIT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic por_n,
	input wire logic [1:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic global_irq_en,
	input wire logic self_prog_busy,
	output logic core_stall,
	output logic ready_irq,
	output logic prog_busy
);

	localparam int DEPTH = 1 << ADDR_W;
	localparam int TW = $clog2(ATOMIC_CYC + SPLIT_CYC + 1);
	localparam int HI_W = ADDR_W - 8;

	// ***********************************
	// elaboration checks
	// ***********************************
	if (ADDR_W < 9 || ADDR_W > 11) begin : g_bad_addr
		$error("ADDR_W must be 9, 10 or 11");
	end
	if (ATOMIC_CYC < 1 || SPLIT_CYC < 1) begin : g_bad_time
		$error("programming times must be at least one cycle");
	end

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PROG = 2'b01,
		ST_COMMIT = 2'b11
	} prog_state_t;

	function automatic logic [TW-1:0] prog_time(input prog_mode_t m);
		if (m == MODE_ATOMIC) begin
			prog_time = TW'(ATOMIC_CYC);
		end else begin
			prog_time = TW'(SPLIT_CYC);
		end
	endfunction : prog_time

	function automatic logic wr_hit(input logic [1:0] idx,
		input logic wr, input logic [1:0] a);
		wr_hit = wr && (a == idx);
	endfunction : wr_hit

	// ***********************************
	// reset and core-side synchronisers
	// ***********************************
	logic rst_meta_q;
	logic rst_sync_q;
	logic spm_meta_q;
	logic spm_q;
	logic gie_meta_q;
	logic gie_q;

	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= rstn;
			rst_sync_q <= rst_meta_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			spm_meta_q <= 1'b0;
			spm_q <= 1'b0;
			gie_meta_q <= 1'b0;
			gie_q <= 1'b0;
		end else begin
			spm_meta_q <= self_prog_busy;
			spm_q <= spm_meta_q;
			gie_meta_q <= global_irq_en;
			gie_q <= gie_meta_q;
		end
	end

	// ***********************************
	// register write decode
	// ***********************************
	logic ctl_wr;
	logic dat_wr;
	logic alo_wr;
	logic ahi_wr;
	logic busy;
	logic mwe_q;
	logic [2:0] mwe_cnt_q;
	logic start;
	logic rd_start;
	prog_state_t state_q;
	prog_mode_t mode_q;

	assign ctl_wr = wr_hit(IDX_CONTROL, io_wr, io_addr);
	assign dat_wr = wr_hit(IDX_DATA, io_wr, io_addr);
	assign alo_wr = wr_hit(IDX_ADDR_LOW, io_wr, io_addr);
	assign ahi_wr = wr_hit(IDX_ADDR_HIGH, io_wr, io_addr);
	assign busy = (state_q != ST_IDLE);

	// qualified strobe: master enable alive, no self-program, valid mode
	assign start = ctl_wr && io_wdata[BIT_WRITE_STROBE] && !busy
		&& mwe_q
		&& !spm_q
		&& (mode_q != MODE_RESERVED);
	assign rd_start = ctl_wr && io_wdata[BIT_READ_STROBE]
		&& !busy && !start;

	// ***********************************
	// address register pair
	// ***********************************
	logic [ADDR_W-1:0] addr_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			addr_q <= '0;
		end else if (!busy) begin
			if (alo_wr) begin
				addr_q[7:0] <= io_wdata;
			end
			if (ahi_wr) begin
				addr_q[ADDR_W-1:8] <= io_wdata[HI_W-1:0];
			end
		end
	end

	// ***********************************
	// master write enable and its four-cycle window
	// ***********************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mwe_q <= 1'b0;
			mwe_cnt_q <= '0;
		end else if (ctl_wr && io_wdata[BIT_MASTER_WE] && !mwe_q) begin
			mwe_q <= 1'b1;
			mwe_cnt_q <= 3'(MWE_CYCLES - 1);
		end else if (ctl_wr && !io_wdata[BIT_MASTER_WE]
			&& !io_wdata[BIT_WRITE_STROBE]) begin
			mwe_q <= 1'b0;
			mwe_cnt_q <= '0;
		end else if (mwe_q) begin
			if (mwe_cnt_q == '0) begin
				mwe_q <= 1'b0;
			end else begin
				mwe_cnt_q <= mwe_cnt_q - 3'h1;
			end
		end
	end

	// ***********************************
	// ready interrupt enable
	// ***********************************
	logic rie_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rie_q <= 1'b0;
		end else if (ctl_wr) begin
			rie_q <= io_wdata[BIT_READY_IE];
		end
	end

	// ***********************************
	// programming engine: survives core reset while busy
	// ***********************************
	logic [TW-1:0] timer_q;
	logic [ADDR_W-1:0] prog_addr_q;
	logic [7:0] prog_data_q;
	logic [7:0] data_q;
	logic arr_wr;

	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			mode_q <= MODE_ATOMIC;
		end else if (!rst_sync_q && !busy) begin
			mode_q <= MODE_ATOMIC;
		end else if (ctl_wr && !busy && !start) begin
			mode_q <= prog_mode_t'(io_wdata[BIT_MODE_HI:BIT_MODE_LO]);
		end
	end

	always_ff @(posedge ref_clk or negedge por_n) begin
		if (!por_n) begin
			state_q <= ST_IDLE;
			timer_q <= '0;
			prog_addr_q <= '0;
			prog_data_q <= DATA_RESET;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start && rst_sync_q) begin
						state_q <= ST_PROG;
						timer_q <= prog_time(mode_q);
						prog_addr_q <= addr_q;
						prog_data_q <= data_q;
					end
				end
				ST_PROG: begin
					if (timer_q <= TW'(1)) begin
						state_q <= ST_COMMIT;
					end else begin
						timer_q <= timer_q - TW'(1);
					end
				end
				ST_COMMIT: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign arr_wr = (state_q == ST_COMMIT);

	// ***********************************
	// data register and array read
	// ***********************************
	logic rd_pend_q;
	logic [7:0] arr_rdata;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_pend_q <= 1'b0;
		end else begin
			rd_pend_q <= rd_start;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			data_q <= DATA_RESET;
		end else if (rd_pend_q) begin
			data_q <= arr_rdata;
		end else if (dat_wr) begin
			data_q <= io_wdata;
		end
	end

	nv_array #(
		.ADDR_W(ADDR_W),
		.DEPTH(DEPTH)
	) u_array (
		.ref_clk(ref_clk),
		.rd_en(rd_start),
		.rd_addr(addr_q),
		.rd_data(arr_rdata),
		.wr_en(arr_wr),
		.wr_addr(prog_addr_q),
		.wr_mode(mode_q),
		.wr_data(prog_data_q)
	);

	// ***********************************
	// core stall
	// ***********************************
	logic [2:0] stall_cnt_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stall_cnt_q <= '0;
			core_stall <= 1'b0;
		end else if (rd_start) begin
			stall_cnt_q <= 3'(READ_STALL_CYCLES - 1);
			core_stall <= 1'b1;
		end else if (start) begin
			stall_cnt_q <= 3'(WRITE_STALL_CYCLES - 1);
			core_stall <= 1'b1;
		end else if (stall_cnt_q != '0) begin
			stall_cnt_q <= stall_cnt_q - 3'h1;
		end else begin
			core_stall <= 1'b0;
		end
	end

	// ***********************************
	// ready interrupt and status outputs
	// ***********************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ready_irq <= 1'b0;
			prog_busy <= 1'b0;
		end else begin
			ready_irq <= rie_q && gie_q && !busy && !start && !spm_q;
			prog_busy <= busy || start;
		end
	end

	// ***********************************
	// register read port
	// ***********************************
	logic [7:0] ctl_view;
	logic [7:0] ahi_view;

	always_comb begin
		ctl_view = '0;
		ctl_view[BIT_MODE_HI:BIT_MODE_LO] = mode_q;
		ctl_view[BIT_READY_IE] = rie_q;
		ctl_view[BIT_MASTER_WE] = mwe_q;
		ctl_view[BIT_WRITE_STROBE] = busy;
		ahi_view = '0;
		ahi_view[HI_W-1:0] = addr_q[ADDR_W-1:8];
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			io_rdata <= '0;
		end else if (io_rd) begin
			unique case (io_addr)
				IDX_CONTROL: io_rdata <= ctl_view;
				IDX_DATA: io_rdata <= data_q;
				IDX_ADDR_LOW: io_rdata <= addr_q[7:0];
				IDX_ADDR_HIGH: io_rdata <= ahi_view;
			endcase
		end
	end

endmodule : nv_access

//--- verilog/nv_access_pkg.sv
// nonvolatile data array access: register indices, fields, timing
// assumes a processor core on ref_clk reaching the registers by index
package nv_access_pkg;

	// ***********************************
	// register indices in the i/o window
	// ***********************************
	localparam logic [1:0] IDX_CONTROL = 2'h0;
	localparam logic [1:0] IDX_DATA = 2'h1;
	localparam logic [1:0] IDX_ADDR_LOW = 2'h2;
	localparam logic [1:0] IDX_ADDR_HIGH = 2'h3;

	// ***********************************
	// control register fields
	// ***********************************
	localparam int BIT_READ_STROBE = 0;
	localparam int BIT_WRITE_STROBE = 1;
	localparam int BIT_MASTER_WE = 2;
	localparam int BIT_READY_IE = 3;
	localparam int BIT_MODE_LO = 4;
	localparam int BIT_MODE_HI = 5;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	typedef enum logic [1:0] {
		MODE_ATOMIC = 2'h0,
		MODE_ERASE = 2'h1,
		MODE_WRITE = 2'h2,
		MODE_RESERVED = 2'h3
	} prog_mode_t;

	// ***********************************
	// timing
	// ***********************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int ATOMIC_TIME_NS = 3400000;
	localparam int SPLIT_TIME_NS = 1800000;
	localparam int ATOMIC_CYCLES =
		(ATOMIC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SPLIT_CYCLES =
		(SPLIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MWE_CYCLES = 4;
	localparam int READ_STALL_CYCLES = 4;
	localparam int WRITE_STALL_CYCLES = 2;

endpackage : nv_access_pkg

//--- verilog/nv_array.sv
// byte-wide nonvolatile array model with registered read data
// assumes one read or one program per cycle, driven by nv_access
module nv_array
	import nv_access_pkg::*;
#(
	parameter int ADDR_W = 11,
	parameter int DEPTH = 2048
) (
	input wire logic ref_clk,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire prog_mode_t wr_mode,
	input wire logic [7:0] wr_data
);

	logic [7:0] mem [DEPTH];

	// ***********************************
	// programming: erase sets bits, write only clears bits
	// ***********************************
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			unique case (wr_mode)
				MODE_ATOMIC: mem[wr_addr] <= wr_data;
				MODE_ERASE: mem[wr_addr] <= ERASED_BYTE;
				MODE_WRITE: mem[wr_addr] <= mem[wr_addr] & wr_data;
				MODE_RESERVED: mem[wr_addr] <= mem[wr_addr];
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule : nv_array

//--- tb/core_bus.sv
// core model issuing i/o register accesses to nv_access
// assumes callers enter the tasks just after a falling ref_clk
module core_bus
	import nv_access_pkg::*;
(
	input wire logic ref_clk,
	input wire logic core_stall,
	input wire logic [7:0] io_rdata,
	output logic [1:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// time step in which the strobes were last dropped
	time rel_t;
	initial begin
		io_addr = 2'h0;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// ***
	// accesses
	// ***
	task automatic acc(input logic w, input logic [1:0] a,
		input logic [7:0] d);
		// a strobe just dropped is never raised again in the same step
		if (rel_t == $time) @(negedge ref_clk);
		// an instruction waits while the core is halted
		while (core_stall === 1'b1) @(negedge ref_clk);
		io_addr = a;
		io_wr = w;
		io_rd = !w;
		io_wdata = d;
		@(negedge ref_clk);
		io_wr = 1'b0;
		io_rd = 1'b0;
		// released data flips so stale values never look valid
		io_wdata = ~d;
		rel_t = $time;
	endtask : acc
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		acc(1'b0, a, 8'h00);
		@(negedge ref_clk);
		d = io_rdata;
	endtask : rd
endmodule : core_bus

//--- tb/nv_access_sva.sv
// port-level checks on nv_access
// assumes a single clock ref_clk and core reset rstn
module nv_access_sva
	import nv_access_pkg::*;
#(
	parameter int ADDR_W = 11,
	parameter int ATOMIC_CYC = ATOMIC_CYCLES,
	parameter int SPLIT_CYC = SPLIT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic por_n,
	input wire logic [1:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic global_irq_en,
	input wire logic self_prog_busy,
	input wire logic core_stall,
	input wire logic ready_irq,
	input wire logic prog_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic [2:0] age_q;
	logic [2:0] idle_q;
	logic ie_q;
	int busy_q;
	wire ctl_wr = io_wr && io_addr == IDX_CONTROL;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) age_q <= 3'h7;
		else if (ctl_wr && !io_wdata[1])
			age_q <= io_wdata[2] ? 3'h0 : 3'h7;
		else if (age_q != 3'h7) age_q <= age_q + 3'h1;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) ie_q <= 1'b0;
		else if (ctl_wr) ie_q <= io_wdata[3];
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) idle_q <= 3'h0;
		else if (ie_q && global_irq_en && !self_prog_busy && !prog_busy
			&& !(ctl_wr && io_wdata[1]))
			idle_q <= idle_q + {2'h0, idle_q != 3'h7};
		else idle_q <= 3'h0;
	end
	always_ff @(posedge ref_clk) begin
		busy_q <= prog_busy ? busy_q + 1 : 0;
	end
	// ***
	// assertions
	// ***
	rd_stall_a: assert property (
		ctl_wr && io_wdata[1:0] == 2'h1 && !prog_busy
		|=> core_stall [*4] ##1 !core_stall)
		else $error("read stall wrong");
	wr_stall_a: assert property (
		$rose(prog_busy) |-> core_stall [*2] ##1 !core_stall)
		else $error("write stall wrong");
	ctl_zero_a: assert property (
		io_rd && io_addr == IDX_CONTROL |=> io_rdata[7:6] == 2'h0)
		else $error("control top bits set");
	addr_zero_a: assert property (
		io_rd && io_addr == IDX_ADDR_HIGH
		|=> (io_rdata >> (ADDR_W - 8)) == 8'h00)
		else $error("addr top set");
	late_strobe_a: assert property (
		ctl_wr && io_wdata[2:1] == 2'h1 && age_q > 3'h3
		|=> !$rose(prog_busy))
		else $error("write without enable");
	strobe_go_a: assert property (
		ctl_wr && io_wdata[2:1] == 2'h1 && age_q < 3'h4
		&& !prog_busy && !self_prog_busy && io_wdata[5:4] != 2'h3
		|=> prog_busy)
		else $error("write not started");
	busy_len_a: assert property (
		prog_busy |-> busy_q <= ATOMIC_CYC + 2)
		else $error("programming too long");
	busy_min_a: assert property (
		$fell(prog_busy) |-> busy_q >= SPLIT_CYC)
		else $error("programming too short");
	irq_quiet_a: assert property (
		prog_busy && $past(prog_busy) |-> !ready_irq)
		else $error("irq during write");
	irq_gate_a: assert property (
		!global_irq_en [*4] |-> !ready_irq)
		else $error("irq without global enable");
	irq_level_a: assert property (
		idle_q == 3'h7 |-> ready_irq)
		else $error("irq missing");
	cover property ($rose(prog_busy));
	cover property ($rose(ready_irq));
	cover property ($rose(core_stall));
endmodule : nv_access_sva
bind nv_access nv_access_sva #(.ADDR_W(ADDR_W), .ATOMIC_CYC(ATOMIC_CYC),
	.SPLIT_CYC(SPLIT_CYC)) i_sva (.*);

//--- tb/eeprom_access_control_tb_top.sv
// self-checking bench for nv_access with shortened program times
// assumes core_bus drives the register side
module eeprom_access_control_tb_top;
	import nv_access_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch %0t got %h exp %h", $time, g, e); end end
	typedef struct {logic [1:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	logic ref_clk, rstn, por_n, io_wr, io_rd, global_irq_en, self_prog_busy;
	logic core_stall, ready_irq, prog_busy;
	logic [1:0] io_addr;
	logic [7:0] io_wdata, io_rdata, r;
	int bad_count, n_checks, cycles, n;
	row_t rows[5] = '{'{IDX_DATA, 8'ha5, 8'ha5}, '{IDX_ADDR_LOW, 8'h3c, 8'h3c},
		'{IDX_ADDR_HIGH, 8'hff, 8'h07}, '{IDX_CONTROL, 8'hf8, 8'h38},
		'{IDX_CONTROL, 8'h08, 8'h08}};
	logic [7:0] dat[4] = '{8'h5a, 8'h00, 8'h0f, 8'h00};
	logic [7:0] expv[4] = '{8'h5a, 8'hff, 8'h0f, 8'h0f};
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	nv_access #(.ATOMIC_CYC(20), .SPLIT_CYC(10)) i_dut (.ref_clk(ref_clk),
		.rstn(rstn), .por_n(por_n), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.global_irq_en(global_irq_en), .self_prog_busy(self_prog_busy),
		.core_stall(core_stall), .ready_irq(ready_irq), .prog_busy(prog_busy));
	core_bus i_core (.ref_clk(ref_clk), .core_stall(core_stall),
		.io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata));
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
	end
	// ***
	// tasks
	// ***
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	// control write, then count the cycles the core is held
	task automatic ctl(input logic [7:0] d, output int k);
		i_core.wr(IDX_CONTROL, d);
		k = 0;
		while (core_stall === 1'b1 && k < 9) begin
			k++;
			@(negedge ref_clk);
		end
	endtask : ctl
	task automatic prog(input logic [1:0] m, input logic [7:0] d);
		i_core.wr(IDX_DATA, d);
		ctl({2'h0, m, 4'h4}, n);
		ctl({2'h0, m, 4'h2}, n);
	endtask : prog
	// ***
	// main sequence
	// ***
	initial begin
		{rstn, por_n, global_irq_en, self_prog_busy} = 4'h0;
		bad_count = 0;
		n_checks = 0;
		cycles = 0;
		repeat (12) @(negedge ref_clk);
		{rstn, por_n} = 2'h3;
		repeat (3) @(negedge ref_clk);
		i_core.rd(IDX_CONTROL, r);
		`CHK(r, 8'h00)
		i_core.rd(IDX_DATA, r);
		`CHK(r, DATA_RESET)
		foreach (rows[i]) begin
			i_core.wr(rows[i].a, rows[i].d);
			i_core.rd(rows[i].a, r);
			`CHK(r, rows[i].e)
		end
		i_core.wr(IDX_ADDR_HIGH, 8'h07);
		i_core.wr(IDX_ADDR_LOW, 8'hff);
		for (int m = 0; m < 4; m++) begin
			prog(m[1:0], dat[m]);
			if (m < 3) `CHK(n, 2)
			else `CHK(prog_busy, 1'b0)
			if (m == 0) begin
				i_core.wr(IDX_ADDR_LOW, 8'h00);
				i_core.wr(IDX_CONTROL, 8'h10);
				i_core.rd(IDX_ADDR_LOW, r);
				`CHK(r, 8'hff)
				i_core.rd(IDX_CONTROL, r);
				`CHK(r, 8'h02)
			end
			for (int i = 0; i < 60; i++) begin
				i_core.rd(IDX_CONTROL, r);
				if (r[1] === 1'b0) break;
			end
			`CHK(r[1], 1'b0)
			ctl(8'h01, n);
			`CHK(n, 4)
			i_core.rd(IDX_DATA, r);
			`CHK(r, expv[m])
		end
		ctl(8'h04, n);
		i_core.rd(IDX_CONTROL, r);
		`CHK(r, 8'h04)
		repeat (4) @(negedge ref_clk);
		i_core.rd(IDX_CONTROL, r);
		`CHK(r, 8'h00)
		ctl(8'h02, n);
		`CHK(prog_busy, 1'b0)
		global_irq_en = 1'b1;
		ctl(8'h08, n);
		repeat (8) @(negedge ref_clk);
		`CHK(ready_irq, 1'b1)
		global_irq_en = 1'b0;
		repeat (6) @(negedge ref_clk);
		`CHK(ready_irq, 1'b0)
		{global_irq_en, self_prog_busy} = 2'h3;
		repeat (6) @(negedge ref_clk);
		`CHK(ready_irq, 1'b0)
		prog(2'h0, 8'h11);
		`CHK(prog_busy, 1'b0)
		self_prog_busy = 1'b0;
		repeat (6) @(negedge ref_clk);
		// enabled ready interrupt across a real write
		i_core.wr(IDX_DATA, 8'h3c);
		ctl(8'h0c, n);
		ctl(8'h0a, n);
		`CHK(ready_irq, 1'b0)
		for (int i = 0; i < 60; i++) begin
			i_core.rd(IDX_CONTROL, r);
			if (r[1] === 1'b0) break;
		end
		repeat (4) @(negedge ref_clk);
		`CHK(ready_irq, 1'b1)
		ctl(8'h09, n);
		i_core.rd(IDX_DATA, r);
		`CHK(r, 8'h3c)
		stop_test();
	end
endmodule : eeprom_access_control_tb_top
